// ==== design/eeprom_loader_pkg.sv ====
// Constants for the serial EEPROM configuration loader.
// Assumes a 10 MHz core clock and 16-bit word EEPROMs.
package eeprom_loader_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned SK_HZ             = 1_250_000;
  localparam int unsigned SK_HALF_CYC       = CLK_HZ / (2 * SK_HZ);
  localparam logic [3:0]  READ_OP           = 4'h0006;
  localparam int unsigned READ_OP_BITS      = 3;
  localparam int unsigned WORD_BITS         = 16;
  localparam int unsigned MAX_ADDR_BITS     = 10;
  localparam int unsigned MIN_ADDR_BITS     = 6;
  localparam int unsigned CTRL_OVERRUN_BIT  = 30;
  localparam int unsigned CTRL_RELOAD_BIT   = 29;
  localparam int unsigned CTRL_VALID_BIT    = 28;
  localparam int unsigned CTRL_PIN_LO       = 24;
  // Arbitrary signature values
  localparam logic [11:0] COMPAT_SIG        = 12'h0A5C;
  localparam logic [7:0]  ENH_SIG           = 8'h005A;
  localparam int unsigned COMPAT_ZONES      = 3;
  localparam int unsigned ENH_ZONES         = 5;
  localparam int unsigned MORE_BIT          = 15;
  localparam int unsigned OFFS_HI           = 14;
  localparam int unsigned OFFS_LO           = 8;
  typedef enum logic [1:0] {SEL_IDLE, SEL_RUN} dummy_t;
endpackage

// ==== design/eeprom_word_reader.sv ====
// Serial EEPROM word reader: read opcode, address, then 16 data bits.
// Assumes one-cycle request while idle; sk_en_i is the half-period tick.
`timescale 1ns/1ns
`default_nettype none
module eeprom_word_reader (
  // Clock and reset
  input  wire logic                                          clk_i,
  input  wire logic                                          rstn_i,
  input  wire logic                                          sk_en_i,
  // Request
  input  wire logic                                          start_i,
  input  wire logic [eeprom_loader_pkg::MAX_ADDR_BITS-1:0]  addr_i,
  input  wire logic [3:0]                                    abits_i,
  output logic                                               done_o,
  output logic [eeprom_loader_pkg::WORD_BITS-1:0]            data_o,
  output logic                                               dummy0_o,
  // Pins
  output logic                                               sk_o,
  output logic                                               cs_o,
  output logic                                               di_o,
  input  wire logic                                          do_sync_i
);
  import eeprom_loader_pkg::*;
  typedef enum {IDLE, SHIFT_OUT, SHIFT_IN, FINISH} rd_state_t;
  rd_state_t   state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic        sk, next_sk, cs, next_cs, di, next_di, dz, next_dz, dn, next_dn;
  logic [15:0] data, next_data;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_sh    = sh;
    next_sk    = sk;
    next_cs    = cs;
    next_di    = di;
    next_dz    = dz;
    next_dn    = 1'b0;
    next_data  = data;
    unique case (state)
      IDLE: begin
        if (start_i) begin
          next_cs    = 1'b1;
          next_sh    = 16'(({READ_OP[2:0], 10'h0000} | 13'(addr_i << (MAX_ADDR_BITS - abits_i))) << 3);
          next_di    = next_sh[15];
          next_cnt   = 5'(READ_OP_BITS + abits_i);
          next_state = SHIFT_OUT;
        end
      end
      // Data to the memory changes on falling edges only, so it is stable at each rise
      SHIFT_OUT: if (sk_en_i) begin
        next_sk = ~sk;
        if (sk) begin
          if (cnt == 5'h0001) begin
            // Memory answers a zero once the whole address is in
            next_dz    = ~do_sync_i;
            next_di    = 1'b0;
            next_cnt   = 5'(WORD_BITS);
            next_state = SHIFT_IN;
          end else begin
            next_di  = sh[14];
            next_sh  = {sh[14:0], 1'b0};
            next_cnt = cnt - 5'h0001;
          end
        end
      end
      SHIFT_IN: if (sk_en_i) begin
        next_sk = ~sk;
        if (sk) begin
          next_data = {data[14:0], do_sync_i};
          next_cnt  = cnt - 5'h0001;
          if (cnt == 5'h0001) next_state = FINISH;
        end
      end
      FINISH: begin
        next_cs    = 1'b0;
        next_sk    = 1'b0;
        next_dn    = 1'b1;
        next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= IDLE;
      cnt   <= '0;
      sh    <= '0;
      sk    <= 1'b0;
      cs    <= 1'b0;
      di    <= 1'b0;
      dz    <= 1'b0;
      dn    <= 1'b0;
      data  <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      sh    <= next_sh;
      sk    <= next_sk;
      cs    <= next_cs;
      di    <= next_di;
      dz    <= next_dz;
      dn    <= next_dn;
      data  <= next_data;
    end
  end

  assign sk_o     = sk;
  assign cs_o     = cs;
  assign di_o     = di;
  assign done_o   = dn;
  assign data_o   = data;
  assign dummy0_o = dz;

  a_done_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i) done_o |=> !done_o)
    else $error("done held too long");
  a_cs_framed: assert property (@(posedge clk_i) disable iff (!rstn_i) $rose(cs_o) |-> $past(start_i))
    else $error("select rose without request");
endmodule
`default_nettype wire

// ==== design/eeprom_config_loader.sv ====
// Top of the serial EEPROM configuration loader.
// Assumes a bus-reset pulse on the core clock and a write port into local registers.
// How it works
// - After bus reset, read EEPROM and write configuration; stop on absence or end.
// - With no EEPROM attached, nothing is written and defaults stay.
// - Four pins: serial clock, select, data to memory, data from memory.
// - Each read shifts out opcode and address, then shifts in 16 bits.
// - Address width is detected from the dummy zero and used thereafter.
// - While loading, every bus access is answered with retry.
// - A read past the detected size stops loading and sets overrun bit 30.
// - Overrun does not reset; already written values remain.
// - After loading, control bits 27:24 drive and sample the pins directly.
// - Writing control bit 29 starts a reload from the EEPROM.
// - Image is zones of whole words; zone 0 is always the header.
// - Compatible mode has three data zones; enhanced mode has five.
// - Compatible header bits 15:4 must match signature; match sets valid bit 28.
// - Compatible header bits 2,1,0 flag zones one to three present.
// - Enhanced header bits 15:8 match signature; bits 4:0 flag zones one to five.
// - Present zones follow each other; absent zones take no words.
// - Zone words hold more flag bit 15, offset 14:8, value 7:0.
`timescale 1ns/1ns
`default_nettype none
module eeprom_config_loader (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Start and mode
  input  wire logic        bus_reset_i,
  input  wire logic        enhanced_i,
  // Bus retry
  input  wire logic        bus_access_i,
  output logic             bus_retry_o,
  // Software control bits
  input  wire logic        ctrl_reload_i,
  input  wire logic [3:0]  ctrl_pins_i,
  output logic [3:0]       ctrl_pins_o,
  output logic             valid_o,
  output logic             overrun_o,
  output logic             busy_o,
  // Configuration write port
  output logic             cfg_we_o,
  output logic [2:0]       cfg_zone_o,
  output logic [6:0]       cfg_offset_o,
  output logic [7:0]       cfg_data_o,
  // EEPROM pins
  output logic             ee_sk_o,
  output logic             ee_cs_o,
  output logic             ee_di_o,
  input  wire logic        ee_do_i
);
  import eeprom_loader_pkg::*;
  typedef enum {IDLE, PROBE, PROBE_WAIT, HEADER, READ, WAIT_WORD, DONE_ST} ld_state_t;
  ld_state_t state, next_state;
  logic [1:0]  do_sync;
  logic [3:0]  abits, next_abits;
  logic [9:0]  addr, next_addr;
  logic [4:0]  zones, next_zones;
  logic [2:0]  zone, next_zone;
  logic        valid, next_valid, ovr, next_ovr;
  logic        we, next_we;
  logic [6:0]  offs, next_offs;
  logic [7:0]  val, next_val;
  logic [2:0]  wz, next_wz;
  logic [5:0]  div, next_div;
  logic        sk_en, rd_start, rd_done, rd_dz;
  logic [15:0] rd_data;
  logic        sk, cs, di;
  logic        req_pend, next_req_pend;

  // Pin input synchroniser
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) do_sync <= 2'b00;
    else         do_sync <= {do_sync[0], ee_do_i};
  end

  // Serial clock half-period tick
  always_comb next_div = (div == 6'(SK_HALF_CYC - 1)) ? 6'h0000 : div + 6'h0001;
  assign sk_en = (div == 6'(SK_HALF_CYC - 1));

  function automatic logic [4:0] header_zones(input logic enh, input logic [15:0] w);
    if (enh) return {w[4], w[3], w[2], w[1], w[0]};
    else     return {w[2], w[1], w[0], 2'b00};
  endfunction

  function automatic logic [2:0] first_zone(input logic [4:0] z, input logic [2:0] after);
    logic [2:0] r;
    r = 3'h0007;
    for (int i = 5; i >= 1; i--) if (z[5 - i] && 3'(i) > after) r = 3'(i);
    return r;
  endfunction

  function automatic logic header_ok(input logic enh, input logic [15:0] w);
    if (enh) return w[15:8] == ENH_SIG;
    else     return w[15:4] == COMPAT_SIG;
  endfunction

  // Next word would lie beyond the detected size
  function automatic logic past_end(input logic [9:0] a, input logic [3:0] n);
    return (11'(a) + 11'h0001) >= (11'h0001 << n);
  endfunction

  eeprom_word_reader u_reader (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .sk_en_i   (sk_en),
    .start_i   (rd_start),
    .addr_i    (addr),
    .abits_i   (abits),
    .done_o    (rd_done),
    .data_o    (rd_data),
    .dummy0_o  (rd_dz),
    .sk_o      (sk),
    .cs_o      (cs),
    .di_o      (di),
    .do_sync_i (do_sync[1])
  );

  assign rd_start = (state == PROBE) || (state == HEADER) || (state == READ);

  always_comb begin
    next_state    = state;
    next_abits    = abits;
    next_addr     = addr;
    next_zones    = zones;
    next_zone     = zone;
    next_valid    = valid;
    next_ovr      = ovr;
    next_we       = 1'b0;
    next_offs     = offs;
    next_val      = val;
    next_wz       = wz;
    next_req_pend = req_pend | bus_reset_i | ctrl_reload_i;
    unique case (state)
      IDLE, DONE_ST: begin
        if (req_pend) begin
          next_req_pend = bus_reset_i | ctrl_reload_i;
          next_valid    = 1'b0;
          next_ovr      = 1'b0;
          next_abits    = 4'(MIN_ADDR_BITS);
          next_addr     = '0;
          next_state    = PROBE;
        end
      end
      PROBE: next_state = PROBE_WAIT;
      PROBE_WAIT: if (rd_done) begin
        if (rd_dz) begin
          next_state = HEADER;
        end else if (abits == 4'(MAX_ADDR_BITS)) begin
          next_state = DONE_ST;
        end else begin
          next_abits = abits + 4'h0001;
          next_state = PROBE;
        end
      end
      HEADER: begin
        next_addr  = '0;
        next_zone  = 3'h0000;
        next_state = WAIT_WORD;
      end
      READ: next_state = WAIT_WORD;
      WAIT_WORD: if (rd_done) begin
        if (zone == 3'h0000) begin
          if (header_ok(enhanced_i, rd_data)) begin
            next_valid = 1'b1;
            next_zones = header_zones(enhanced_i, rd_data);
            next_zone  = first_zone(header_zones(enhanced_i, rd_data), 3'h0000);
          end else begin
            next_zone  = 3'h0007;
          end
        end else begin
          next_we   = 1'b1;
          next_wz   = zone;
          next_offs = rd_data[OFFS_HI:OFFS_LO];
          next_val  = rd_data[7:0];
          if (!rd_data[MORE_BIT]) next_zone = first_zone(zones, zone);
        end
        if (next_zone == 3'h0007) begin
          next_state = DONE_ST;
        end else if (past_end(addr, abits)) begin
          next_ovr   = 1'b1;
          next_state = DONE_ST;
        end else begin
          next_addr  = addr + 10'h0001;
          next_state = READ;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= IDLE;
      div      <= '0;
      abits    <= 4'(MIN_ADDR_BITS);
      addr     <= '0;
      zones    <= '0;
      zone     <= '0;
      valid    <= 1'b0;
      ovr      <= 1'b0;
      we       <= 1'b0;
      offs     <= '0;
      val      <= '0;
      wz       <= '0;
      req_pend <= 1'b0;
    end else begin
      state    <= next_state;
      div      <= next_div;
      abits    <= next_abits;
      addr     <= next_addr;
      zones    <= next_zones;
      zone     <= next_zone;
      valid    <= next_valid;
      ovr      <= next_ovr;
      we       <= next_we;
      offs     <= next_offs;
      val      <= next_val;
      wz       <= next_wz;
      req_pend <= next_req_pend;
    end
  end

  logic loading;
  assign loading      = (state != IDLE) && (state != DONE_ST);
  assign busy_o       = loading;
  assign bus_retry_o  = loading & bus_access_i;
  assign valid_o      = valid;
  assign overrun_o    = ovr;
  assign cfg_we_o     = we;
  assign cfg_zone_o   = wz;
  assign cfg_offset_o = offs;
  assign cfg_data_o   = val;
  // Software bit-bang after load: bits are sk, cs, di, do
  assign ee_sk_o      = loading ? sk : ctrl_pins_i[0];
  assign ee_cs_o      = loading ? cs : ctrl_pins_i[1];
  assign ee_di_o      = loading ? di : ctrl_pins_i[2];
  assign ctrl_pins_o  = {do_sync[1], ee_di_o, ee_cs_o, ee_sk_o};

  a_retry_loading: assert property (@(posedge clk_i) disable iff (!rstn_i) (busy_o && bus_access_i) |-> bus_retry_o)
    else $error("access not retried while loading");
  a_no_write_invalid: assert property (@(posedge clk_i) disable iff (!rstn_i) cfg_we_o |-> valid_o)
    else $error("zone data written without valid header");
  a_overrun_ends: assert property (@(posedge clk_i) disable iff (!rstn_i) $rose(overrun_o) |-> !busy_o)
    else $error("overrun did not end load");
  a_reload_starts: assert property (@(posedge clk_i) disable iff (!rstn_i) (ctrl_reload_i && !busy_o) |-> ##[1:3] busy_o)
    else $error("reload did not start");

  // Named steps of a load
  sequence load_request;
    (bus_reset_i || ctrl_reload_i) && !busy_o;
  endsequence

  sequence load_running;
    ##[1:3] busy_o;
  endsequence

  sequence header_seen;
    (state == WAIT_WORD) && rd_done && (zone == 3'h0000);
  endsequence

  sequence write_pulse;
    cfg_we_o ##1 !cfg_we_o;
  endsequence

  a_request_loads: assert property (@(posedge clk_i) disable iff (!rstn_i) load_request |-> load_running)
    else $error("request did not start a load");

  a_absent_ends: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == PROBE_WAIT && rd_done && !rd_dz && abits == 4'(MAX_ADDR_BITS)) |=> (!busy_o && !valid_o))
    else $error("load went on without a memory");

  a_bad_header: assert property (@(posedge clk_i) disable iff (!rstn_i)
    header_seen ##0 !header_ok(enhanced_i, rd_data) |=> (!busy_o && !valid_o))
    else $error("bad header did not end the load");

  a_header_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == HEADER) |=> (state == WAIT_WORD && addr == '0 && zone == 3'h0000))
    else $error("header not read from word zero");

  a_width_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
    busy_o |-> (abits >= 4'(MIN_ADDR_BITS) && abits <= 4'(MAX_ADDR_BITS)))
    else $error("address width out of range");

  a_overrun_when: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == WAIT_WORD && rd_done && zone != 3'h0000 && rd_data[MORE_BIT] && past_end(addr, abits)) |=> overrun_o)
    else $error("read past the end did not flag overrun");

  a_overrun_kept: assert property (@(posedge clk_i) disable iff (!rstn_i) $rose(overrun_o) |-> valid_o)
    else $error("overrun cleared the valid program");

  a_valid_in_load: assert property (@(posedge clk_i) disable iff (!rstn_i) $rose(valid_o) |-> $past(busy_o))
    else $error("valid flag set outside a load");

  a_write_single: assert property (@(posedge clk_i) disable iff (!rstn_i) cfg_we_o |-> write_pulse)
    else $error("configuration write held too long");

  a_write_in_load: assert property (@(posedge clk_i) disable iff (!rstn_i) cfg_we_o |-> $past(busy_o))
    else $error("configuration write outside a load");

  a_sk_paced: assert property (@(posedge clk_i) disable iff (!rstn_i) $changed(sk) |-> $past(sk_en))
    else $error("serial clock moved off its tick");

  a_pins_software: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !busy_o |-> (ee_sk_o == ctrl_pins_i[0] && ee_cs_o == ctrl_pins_i[1] && ee_di_o == ctrl_pins_i[2]))
    else $error("pins not under software control after load");
endmodule
`default_nettype wire

// ==== tb/eeprom_model.sv ====
// Behavioural four-wire serial EEPROM of 16-bit words.
// Assumes the loader clocks it; address width set by abits_i; data line pulled up when idle.
`timescale 1ns/1ns
`default_nettype none
module eeprom_model (
  // Pins
  input  wire logic       sk_i,
  input  wire logic       cs_i,
  input  wire logic       di_i,
  output var  logic       do_o,
  // Setup
  input  wire logic       present_i,
  input  wire logic [3:0] abits_i
);
  logic [15:0] mem [0:1023];
  logic [15:0] word;
  logic [9:0]  adr;
  logic [2:0]  op;
  int          cnt;
  initial do_o = 1'b1;
  always @(posedge sk_i or negedge cs_i) begin
    if (!cs_i) begin
      cnt = 0;
      adr = '0;
      op = '0;
      do_o <= 1'b1;
    end else if (present_i) begin
      cnt++;
      if (cnt <= 3) op = {op[1:0], di_i};
      else if (cnt <= 3 + abits_i) adr = {adr[8:0], di_i};
      if (cnt == 3 + abits_i && op == 3'b110) begin
        word = mem[adr];
        do_o <= 1'b0;
      end else if (cnt > 3 + abits_i && cnt <= 19 + abits_i) begin
        do_o <= word[15];
        word = word << 1;
      end else begin
        do_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_serial_eeprom_config_loader.sv ====
// Self-checking bench for the serial EEPROM configuration loader.
// Assumes the EEPROM model in tb/ and a 10 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_config_loader;
  import eeprom_loader_pkg::*;
  logic        clk_i, rstn_i, bus_reset_i, enhanced_i, bus_access_i;
  logic        ctrl_reload_i, bus_retry_o, valid_o, overrun_o, busy_o;
  logic [3:0]  ctrl_pins_i, ctrl_pins_o, ee_abits;
  logic        cfg_we_o, ee_sk_o, ee_cs_o, ee_di_o, ee_do_i, ee_present;
  logic [2:0]  cfg_zone_o;
  logic [6:0]  cfg_offset_o;
  logic [7:0]  cfg_data_o;
  logic [17:0] wq [$];
  int          bad_count, num_checks, retry_miss, cycles;

  eeprom_config_loader eeprom_config_loader_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus_reset_i(bus_reset_i), .enhanced_i(enhanced_i), .bus_access_i(bus_access_i),
    .bus_retry_o(bus_retry_o), .ctrl_reload_i(ctrl_reload_i), .ctrl_pins_i(ctrl_pins_i),
    .ctrl_pins_o(ctrl_pins_o), .valid_o(valid_o), .overrun_o(overrun_o), .busy_o(busy_o),
    .cfg_we_o(cfg_we_o), .cfg_zone_o(cfg_zone_o), .cfg_offset_o(cfg_offset_o),
    .cfg_data_o(cfg_data_o), .ee_sk_o(ee_sk_o), .ee_cs_o(ee_cs_o), .ee_di_o(ee_di_o),
    .ee_do_i(ee_do_i));
  eeprom_model eeprom_model_inst (.sk_i(ee_sk_o), .cs_i(ee_cs_o), .di_i(ee_di_o),
    .do_o(ee_do_i), .present_i(ee_present), .abits_i(ee_abits));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Ceiling: the whole sequence needs about 20000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  always @(negedge clk_i) begin
    if (cfg_we_o === 1'b1) wq.push_back({cfg_zone_o, cfg_offset_o, cfg_data_o});
    if (busy_o === 1'b1 && bus_access_i && bus_retry_o !== 1'b1) retry_miss++;
  end

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Starts a load by bus reset or reload pulse and waits for it to end
  task automatic run_load(input logic enh, input logic by_reload);
    int n;
    wq.delete();
    retry_miss = 0;
    enhanced_i = enh;
    bus_access_i = 1'b1;
    if (by_reload) ctrl_reload_i = 1'b1;
    else bus_reset_i = 1'b1;
    @(negedge clk_i);
    ctrl_reload_i = 1'b0;
    bus_reset_i = 1'b0;
    n = 0;
    while (busy_o !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    check(busy_o === 1'b1, "load did not start");
    while (busy_o === 1'b1) @(negedge clk_i);
    check(retry_miss == 0, "access not retried during load");
    check(bus_retry_o === 1'b0, "retry after load");
    bus_access_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic expect_writes(input logic [17:0] exp [$]);
    check(wq.size() == exp.size(), "write count");
    foreach (exp[i]) if (i < wq.size()) check(wq[i] === exp[i], "write content");
  endtask

  task automatic t_absent();
    ee_present = 1'b0;
    run_load(1'b0, 1'b0);
    check(wq.size() == 0 && valid_o === 1'b0 && overrun_o === 1'b0, "writes without EEPROM");
    ee_present = 1'b1;
  endtask

  task automatic t_bad_sig();
    ee_abits = 4'h8;
    eeprom_model_inst.mem[0] = 16'h5A1F;
    eeprom_model_inst.mem[1] = 16'h0101;
    run_load(1'b0, 1'b0);
    check(wq.size() == 0 && valid_o === 1'b0, "compat bad header applied");
    eeprom_model_inst.mem[0] = 16'hA5C5;
    run_load(1'b1, 1'b0);
    check(wq.size() == 0 && valid_o === 1'b0, "enhanced bad header applied");
  endtask

  task automatic t_compat();
    ee_abits = 4'h8;
    eeprom_model_inst.mem[0] = 16'hA5C5;
    eeprom_model_inst.mem[1] = 16'h8104;
    eeprom_model_inst.mem[2] = 16'h0233;
    eeprom_model_inst.mem[3] = 16'h0511;
    run_load(1'b0, 1'b0);
    expect_writes('{{3'd1, 7'h01, 8'h04}, {3'd1, 7'h02, 8'h33}, {3'd3, 7'h05, 8'h11}});
    check(valid_o === 1'b1 && overrun_o === 1'b0, "compat valid flag");
  endtask

  task automatic t_enh_reload();
    ee_abits = 4'hA;
    eeprom_model_inst.mem[0] = 16'h5A12;
    eeprom_model_inst.mem[1] = 16'h0A0B;
    eeprom_model_inst.mem[2] = 16'h0C0D;
    run_load(1'b1, 1'b1);
    expect_writes('{{3'd1, 7'h0A, 8'h0B}, {3'd4, 7'h0C, 8'h0D}});
    check(valid_o === 1'b1, "enhanced valid flag");
  endtask

  task automatic t_overrun();
    ee_abits = 4'h6;
    eeprom_model_inst.mem[0] = 16'hA5C4;
    for (int i = 1; i < 64; i++) eeprom_model_inst.mem[i] = {1'b1, i[6:0], i[7:0]};
    run_load(1'b0, 1'b0);
    check(overrun_o === 1'b1, "overrun flag");
    check(wq.size() == 63 && valid_o === 1'b1, "written values lost");
    if (wq.size() == 63) check(wq[62] === {3'd1, 7'h3F, 8'h3F}, "last word");
  endtask

  task automatic t_pins();
    ctrl_pins_i = 4'b0101;
    repeat (3) @(negedge clk_i);
    check({ee_di_o, ee_cs_o, ee_sk_o} === 3'b101 && ctrl_pins_o[2:0] === 3'b101, "pins 101");
    check(ctrl_pins_o[3] === 1'b1, "sampled data line");
    ctrl_pins_i = 4'b0010;
    repeat (3) @(negedge clk_i);
    check({ee_di_o, ee_cs_o, ee_sk_o} === 3'b010 && ctrl_pins_o[3] === ee_do_i, "pins 010");
  endtask

  initial begin
    {bus_reset_i, enhanced_i, bus_access_i, ctrl_reload_i} = 4'h0;
    ctrl_pins_i = 4'h0;
    ee_present = 1'b1;
    ee_abits = 4'h6;
    rstn_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    t_absent();
    t_bad_sig();
    t_compat();
    t_enh_reload();
    t_overrun();
    t_pins();
    print_verdict();
  end
endmodule
`default_nettype wire
